// >>> core/dpram_top.sv
// Data pointer pair, internal RAM and external-move steering
//
// Functional notes
// [RL1] Two 16-bit pointers, exactly one active
// [RL2] Select bit 0 at A2 picks pointer
// [RL3] Bit 2 reads zero; increment toggles select
// [RL4] Software tracks toggle parity itself
// [RL5] Bit 3 is a plain user flag
// [RL6] Reserved bits undefined; software writes zeros
// [RL7] Expanded RAM 1024 bytes at 000-3FF
// [RL8] Addresses 00-7F reach lower RAM
// [RL9] High addresses: direct registers, indirect upper RAM
// [RL10] External select clear: moves hit on-chip RAM
// [RL11] Pointer beyond enabled size goes to bus
// [RL12] Above FF only via pointer moves
// [RL13] Size bits hide upper on-chip RAM
// [RL14] Bus moves multiplex address on ports
// [RL15] Bus moves drive read or write strobe
// [RL16] Stack reaches only internal 256 bytes
// [RL17] Stretch bit lengthens strobes 6 to 30
// [RL18] External select loaded from security byte
// [RL19] Pointer operations touch selected pointer only
// [RL20] Select bit cleared by reset
module dpram_top (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Security configuration byte, external select bit
  input wire logic hsb_external_data_select_sel,
  // Internal data access
  input wire logic ia_req,
  input wire logic ia_we,
  input wire logic ia_indirect,
  input wire logic ia_stack,
  input wire logic [7:0] ia_addr,
  input wire logic [7:0] ia_wdata,
  output logic [7:0] ia_rdata,
  output logic ia_done,
  // Pointer operations
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_val,
  input wire logic ptr_inc,
  output logic [15:0] data_pointer,
  output logic pointer_select,
  // External moves
  input wire logic xm_req,
  input wire logic xm_we,
  input wire logic xm_use_ptr,
  input wire logic [7:0] xm_ri_addr,
  input wire logic [7:0] xm_wdata,
  output logic [7:0] xm_rdata,
  output logic xm_done,
  output logic xm_busy,
  // Control levels
  output logic boot_rom_map_enable,
  output logic ale_movx_only,
  // Multiplexed bus pins
  output logic [7:0] p0_out,
  output logic p0_oe,
  input wire logic [7:0] p0_in,
  output logic [7:0] p2_out,
  output logic p2_oe,
  output logic rd_n,
  output logic wr_n,
  output logic ale
);
  import dpram_pkg::*;

  // ********************************************************
  // Reset release
  // ********************************************************
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  // Upper bound of the visible on-chip RAM, one page per size step
  function automatic logic [10:0] expanded_onchip_ram_limit(input logic [1:0] xrs);
    expanded_onchip_ram_limit = {1'b0, xrs, 8'h00} + 11'h100;
  endfunction

  function automatic logic [15:0] byte_into(input logic [15:0] word, input logic hi, input logic [7:0] b);
    byte_into = hi ? {b, word[7:0]} : {word[15:8], b};
  endfunction

  // ********************************************************
  // Control registers
  // ********************************************************
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [15:0] ptr0_d;
  logic [15:0] ptr1_d;
  logic sel_q;
  logic flag_q;
  logic boot_q;
  logic ext_q;
  logic [1:0] xrs_q;
  logic stretch_q;
  logic ale_mode_q;
  logic strap_done_q;

  // Direct access above 7F is a register access
  wire ia_high = ia_addr[7];
  wire ia_ind = ia_indirect | ia_stack; // RL16
  wire sfr_hit = ia_req && ia_high && !ia_ind; // RL9
  wire ram_hit = ia_req && (!ia_high || ia_ind); // RL8 RL9
  wire sfr_wr = sfr_hit && ia_we;
  wire wr_psel = sfr_wr && (ia_addr == SFR_PTR_SEL);
  wire wr_aux = sfr_wr && (ia_addr == SFR_AUX_MEM);
  wire wr_plo = sfr_wr && (ia_addr == SFR_PTR_LO);
  wire wr_phi = sfr_wr && (ia_addr == SFR_PTR_HI);

  // Only the selected pointer moves; load beats increment beats byte write
  wire [15:0] ptr_cur = sel_q ? ptr1_q : ptr0_q; // RL1 RL2
  wire [15:0] ptr_byte = byte_into(ptr_cur, wr_phi, ia_wdata);
  wire [15:0] ptr_next = ptr_load ? ptr_load_val
    : ptr_inc ? ptr_cur + 16'h0001
    : (wr_plo || wr_phi) ? ptr_byte : ptr_cur;
  assign ptr0_d = sel_q ? ptr0_q : ptr_next; // RL19
  assign ptr1_d = sel_q ? ptr_next : ptr1_q; // RL19

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr0_q <= PTR_RESET;
      ptr1_q <= PTR_RESET;
    end
    else
    begin
      ptr0_q <= ptr0_d; // RL1
      ptr1_q <= ptr1_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= 1'b0; // RL20
      flag_q <= 1'b0;
      boot_q <= 1'b0;
    end
    else if (wr_psel)
    begin
      // Bit 2 is not stored, so an increment of the byte toggles bit 0 only
      sel_q <= ia_wdata[PSEL_SEL_BIT]; // RL2 RL3 RL4
      flag_q <= ia_wdata[PSEL_FLAG_BIT]; // RL5
      boot_q <= ia_wdata[PSEL_BOOT_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_q <= 1'b0;
      strap_done_q <= 1'b0;
      xrs_q <= XRS_RESET;
      stretch_q <= 1'b0;
      ale_mode_q <= 1'b0;
    end
    else
    begin
      strap_done_q <= 1'b1;
      if (!strap_done_q)
      begin
        ext_q <= hsb_external_data_select_sel; // RL18
      end
      else if (wr_aux)
      begin
        ext_q <= ia_wdata[AUX_EXT_BIT];
      end
      if (wr_aux)
      begin
        xrs_q <= ia_wdata[AUX_XRS_HI:AUX_XRS_LO]; // RL13
        stretch_q <= ia_wdata[AUX_STRETCH_BIT]; // RL17
        ale_mode_q <= ia_wdata[AUX_ALE_BIT];
      end
    end
  end

  // ********************************************************
  // Internal RAM and register read-back
  // ********************************************************
  // Lower and upper halves share one array; the mode has already chosen
  logic [7:0] iram_q [IRAM_BYTES];
  logic [7:0] ia_rdata_q;
  logic ia_done_q;

  // Reserved bits read as zero, which software must not rely on
  wire [7:0] psel_rd = {2'b00, boot_q, 1'b0, flag_q, 1'b0, 1'b0, sel_q}; // RL3 RL6
  wire [7:0] aux_rd = {2'b00, stretch_q, 1'b0, xrs_q, ext_q, ale_mode_q}; // RL6
  wire [7:0] sfr_rd = (ia_addr == SFR_PTR_SEL) ? psel_rd
    : (ia_addr == SFR_AUX_MEM) ? aux_rd
    : (ia_addr == SFR_PTR_LO) ? ptr_cur[7:0]
    : (ia_addr == SFR_PTR_HI) ? ptr_cur[15:8] : BYTE_ZERO;

  always_ff @(posedge clock)
  begin
    if (ram_hit && ia_we)
    begin
      iram_q[ia_addr] <= ia_wdata; // RL8 RL16
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ia_rdata_q <= 8'h00;
      ia_done_q <= 1'b0;
    end
    else
    begin
      ia_done_q <= ia_req;
      if (ia_req && !ia_we)
      begin
        ia_rdata_q <= sfr_hit ? sfr_rd : iram_q[ia_addr]; // RL9
      end
    end
  end

  // ********************************************************
  // External move steering
  // ********************************************************
  dpram_mem_if xr_if ();
  dpram_mem_if xb_if ();
  logic busy_q;
  logic xr_req_q;
  logic xb_req_q;
  logic we_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic page_q;
  logic [7:0] xm_rdata_q;
  logic xm_done_q;

  // Register-indirect moves carry an 8-bit address in the first page
  wire [15:0] xm_addr = xm_use_ptr ? ptr_cur : {8'h00, xm_ri_addr}; // RL12
  wire below_limit = (xm_addr < {5'h00, expanded_onchip_ram_limit(xrs_q)}); // RL7 RL13
  wire to_expanded_onchip_ram = !ext_q && (!xm_use_ptr || below_limit); // RL10 RL11
  wire xm_take = xm_req && !busy_q;
  wire xm_fin = xr_if.done || xb_if.done;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      xr_req_q <= 1'b0;
      xb_req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      page_q <= 1'b0;
      xm_rdata_q <= 8'h00;
      xm_done_q <= 1'b0;
    end
    else
    begin
      xr_req_q <= xm_take && to_expanded_onchip_ram; // RL10
      xb_req_q <= xm_take && !to_expanded_onchip_ram; // RL11 RL14
      xm_done_q <= xm_fin;
      if (xm_take)
      begin
        busy_q <= 1'b1;
        we_q <= xm_we;
        addr_q <= xm_addr;
        wdata_q <= xm_wdata;
        page_q <= xm_use_ptr; // RL14
      end
      else if (xm_fin)
      begin
        busy_q <= 1'b0;
        xm_rdata_q <= xr_if.done ? xr_if.rdata : xb_if.rdata;
      end
    end
  end

  assign xr_if.req = xr_req_q;
  assign xr_if.we = we_q;
  assign xr_if.addr = addr_q;
  assign xr_if.wdata = wdata_q;
  assign xr_if.page_out = page_q;
  assign xr_if.stretch = stretch_q;
  assign xb_if.req = xb_req_q;
  assign xb_if.we = we_q;
  assign xb_if.addr = addr_q;
  assign xb_if.wdata = wdata_q;
  assign xb_if.page_out = page_q;
  assign xb_if.stretch = stretch_q; // RL17

  dpram_expanded_onchip_ram #(
    .DEPTH(EXPANDED_ONCHIP_RAM_BYTES)
  ) u_expanded_onchip_ram (
    .clock(clock),
    .rst_n(rst_n),
    .mem(xr_if.slave)
  );

  // Pins move only for bus cycles, so on-chip moves leave them quiet
  dpram_xbus u_xbus (
    .clock(clock),
    .rst_n(rst_n),
    .mem(xb_if.slave),
    .p0_out(p0_out),
    .p0_oe(p0_oe),
    .p0_in(p0_in),
    .p2_out(p2_out),
    .p2_oe(p2_oe),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .ale(ale)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  logic [15:0] ptr_out_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_out_q <= PTR_RESET;
    end
    else
    begin
      ptr_out_q <= ptr_cur;
    end
  end

  assign ia_rdata = ia_rdata_q;
  assign ia_done = ia_done_q;
  assign data_pointer = ptr_out_q;
  assign pointer_select = sel_q;
  assign xm_rdata = xm_rdata_q;
  assign xm_done = xm_done_q;
  assign xm_busy = busy_q;
  assign boot_rom_map_enable = boot_q;
  assign ale_movx_only = ale_mode_q;
endmodule // dpram_top

// >>> core/dpram_pkg.sv
// Constants, field positions and state codes for the data pointer and RAM steering block
package dpram_pkg;
  // Special function register addresses
  localparam logic [7:0] SFR_PTR_SEL = 8'hA2;
  localparam logic [7:0] SFR_AUX_MEM = 8'h8E;
  localparam logic [7:0] SFR_PTR_LO = 8'h82;
  localparam logic [7:0] SFR_PTR_HI = 8'h83;
  // Field positions in pointer_select_and_boot_control
  localparam int PSEL_SEL_BIT = 0;
  localparam int PSEL_ZERO_BIT = 2;
  localparam int PSEL_FLAG_BIT = 3;
  localparam int PSEL_BOOT_BIT = 5;
  // Field positions in aux_memory_control
  localparam int AUX_ALE_BIT = 0;
  localparam int AUX_EXT_BIT = 1;
  localparam int AUX_XRS_LO = 2;
  localparam int AUX_XRS_HI = 3;
  localparam int AUX_STRETCH_BIT = 5;
  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [1:0] XRS_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Memory sizes
  localparam int EXPANDED_ONCHIP_RAM_BYTES = 1024;
  localparam int IRAM_BYTES = 256;
  // Timing, in clock periods of the 40 ns core clock
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [4:0] STROBE_NORM_CLKS = 5'h06;
  localparam logic [4:0] STROBE_LONG_CLKS = 5'h1E;
  // External bus cycle states
  typedef enum logic [4:0] {
    XB_IDLE = 5'b00001,
    XB_ALE = 5'b00010,
    XB_STROBE = 5'b00100,
    XB_HOLD = 5'b01000,
    XB_DONE = 5'b10000
  } dpram_xbus_st_t;
endpackage

// >>> core/dpram_mem_if.sv
// Request and answer bundle between the steering logic and a data-space target
interface dpram_mem_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic page_out;
  logic stretch;
  logic [7:0] rdata;
  logic done;
  modport master (output req, we, addr, wdata, page_out, stretch, input rdata, done);
  modport slave (input req, we, addr, wdata, page_out, stretch, output rdata, done);
endinterface

// >>> core/dpram_expanded_onchip_ram.sv
// On-chip expanded RAM, flip-flop storage with one-cycle answer
module dpram_expanded_onchip_ram #(
  parameter int DEPTH = 1024
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Access port
  dpram_mem_if.slave mem
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] store_q [DEPTH];
  logic [7:0] rdata_q;
  logic done_q;
  wire [AW-1:0] index = mem.addr[AW-1:0];

  always_ff @(posedge clock)
  begin
    if (mem.req && mem.we)
    begin
      store_q[index] <= mem.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= mem.req;
      if (mem.req && !mem.we)
      begin
        rdata_q <= store_q[index];
      end
    end
  end

  assign mem.rdata = rdata_q;
  assign mem.done = done_q;
endmodule // dpram_expanded_onchip_ram

// >>> core/dpram_xbus.sv
// Multiplexed external bus cycle: address latch phase, then read or write strobe
module dpram_xbus (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Request port
  dpram_mem_if.slave mem,
  // Pins
  output logic [7:0] p0_out,
  output logic p0_oe,
  input wire logic [7:0] p0_in,
  output logic [7:0] p2_out,
  output logic p2_oe,
  output logic rd_n,
  output logic wr_n,
  output logic ale
);
  import dpram_pkg::*;
  dpram_xbus_st_t st_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic we_q;
  logic [7:0] wdata_q;
  logic [7:0] p0_s1_q;
  logic [7:0] p0_s2_q;
  logic [7:0] rdata_q;
  logic done_q;
  wire last_strobe = (cnt_q == len_q - 5'h01);

  // Pin data is asynchronous to the core clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
    end
    else
    begin
      p0_s1_q <= p0_in;
      p0_s2_q <= p0_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= XB_IDLE;
      cnt_q <= 5'h00;
      len_q <= STROBE_NORM_CLKS;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      p0_out <= 8'h00;
      p0_oe <= 1'b0;
      p2_out <= 8'h00;
      p2_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      ale <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (st_q)
        XB_IDLE:
        begin
          if (mem.req)
          begin
            st_q <= XB_ALE;
            we_q <= mem.we;
            wdata_q <= mem.wdata;
            len_q <= mem.stretch ? STROBE_LONG_CLKS : STROBE_NORM_CLKS; // RL17
            ale <= 1'b1;
            p0_out <= mem.addr[7:0]; // RL14
            p0_oe <= 1'b1;
            p2_out <= mem.addr[15:8]; // RL14
            p2_oe <= mem.page_out; // RL14
          end
        end
        XB_ALE:
        begin
          ale <= 1'b0;
          cnt_q <= 5'h00;
          st_q <= XB_STROBE;
          p0_out <= wdata_q;
          p0_oe <= we_q;
          wr_n <= !we_q; // RL15
          rd_n <= we_q; // RL15
        end
        XB_STROBE:
        begin
          cnt_q <= cnt_q + 5'h01;
          if (last_strobe)
          begin
            rdata_q <= p0_s2_q;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            st_q <= XB_HOLD;
          end
        end
        XB_HOLD:
        begin
          // Write data held one cycle past the strobe edge
          p0_oe <= 1'b0;
          p2_oe <= 1'b0;
          done_q <= 1'b1;
          st_q <= XB_DONE;
        end
        XB_DONE:
        begin
          st_q <= XB_IDLE;
        end
      endcase
    end
  end

  assign mem.rdata = rdata_q;
  assign mem.done = done_q;
endmodule // dpram_xbus

// >>> sim/dpram_sva.sv
// Port-level checker for the steering block
module dpram_sva
  import dpram_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Internal access
  input wire logic ia_req,
  input wire logic ia_we,
  input wire logic ia_indirect,
  input wire logic ia_stack,
  input wire logic [7:0] ia_addr,
  input wire logic ia_done,
  // Pointers
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_val,
  input wire logic ptr_inc,
  input wire logic [15:0] data_pointer,
  input wire logic pointer_select,
  // Bus pins
  input wire logic xm_busy,
  input wire logic p0_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  wire idle = rd_n && wr_n;
  wire sel_wr = ia_req && ia_we && !ia_indirect && !ia_stack && ia_addr == SFR_PTR_SEL;
  wire quiet = !ia_req && !ptr_load && !ptr_inc;
  AST_EXCL: assert property (rd_n || wr_n)
    else $error("both strobes low");
  AST_MIN: assert property ($fell(idle) |-> !idle [*6])
    else $error("strobe too short");
  AST_MAX: assert property ($fell(idle) |-> ##[6:30] $rose(idle))
    else $error("strobe too long");
  AST_ALE: assert property ($fell(idle) |-> $past(ale))
    else $error("no address phase");
  AST_WDRV: assert property (!wr_n |-> p0_oe)
    else $error("write data not driven");
  AST_RREL: assert property (!rd_n |-> !p0_oe)
    else $error("port driven in read");
  AST_QUIET: assert property (!xm_busy |-> idle && !ale)
    else $error("bus active while idle");
  AST_IA: assert property (ia_req |=> ia_done)
    else $error("internal access unanswered");
  AST_SEL: assert property ($changed(pointer_select) |-> $past(sel_wr))
    else $error("select moved by itself");
  AST_LOAD: assert property (ptr_load && !ia_req ##1 quiet |=> data_pointer == $past(ptr_load_val, 2))
    else $error("pointer load lost");
  AST_INC: assert property (ptr_inc && !ptr_load && !ia_req ##1 quiet |=> data_pointer == $past(data_pointer) + 16'h0001)
    else $error("pointer increment wrong");
  cover property ($fell(rd_n));
  cover property ($fell(wr_n));
  cover property (!rd_n [*8]);
endmodule  // dpram_sva

bind dpram_top dpram_sva chk_u (.clock, .nrst, .ia_req, .ia_we, .ia_indirect, .ia_stack, .ia_addr, .ia_done,
  .ptr_load, .ptr_load_val, .ptr_inc, .data_pointer, .pointer_select, .xm_busy, .p0_oe, .rd_n, .wr_n, .ale);

// >>> sim/dpram_ext_mem.sv
// Memory on the far side of the multiplexed bus
module dpram_ext_mem (
  // Clock
  input wire logic clock,
  // Bus pins
  input wire logic ale,
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic p2_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  // Slow device: data only after ten strobe cycles
  input wire logic slow,
  output logic [7:0] p0_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [15:0]];
  logic [15:0] addr_q = '0;
  logic [7:0] drv_q = 8'h5A;
  int low_q = 0;
  // Released port toggles so a stale byte never looks valid
  assign p0_in = p0_oe ? p0_out : drv_q;
  always @(posedge clock)
  begin
    if (ale)
      addr_q <= {p2_oe ? p2_out : 8'h00, p0_out};
    if (!wr_n)
      mem[addr_q] = p0_out;
    low_q <= rd_n ? 0 : low_q + 1;
    if (!rd_n && low_q + 1 >= (slow ? 10 : 1) && mem.exists(addr_q))
      drv_q <= mem[addr_q];
    else
      drv_q <= ~drv_q;
  end
endmodule  // dpram_ext_mem

// >>> sim/dpram_tb_top.sv
// Self-checking bench for the data pointer and RAM steering block
module dpram_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dpram_pkg::*;
  logic clock = 0, nrst = 0, hsb_external_data_select_sel = 0, slow = 0;
  logic ia_req = 0, ia_we = 0, ia_indirect = 0, ia_stack = 0, ptr_load = 0, ptr_inc = 0;
  logic xm_req = 0, xm_we = 0, xm_use_ptr = 0;
  logic [7:0] ia_addr = '0, ia_wdata = '0, xm_ri_addr = '0, xm_wdata = '0, p0_in, q, a, d;
  logic [15:0] ptr_load_val = '0, v0, v1, xa;
  logic [7:0] ia_rdata, xm_rdata, p0_out, p2_out;
  logic [15:0] data_pointer;
  logic ia_done, xm_done, xm_busy, pointer_select, boot_rom_map_enable, p0_oe, p2_oe, rd_n, wr_n, ale, ale_movx_only;
  logic [31:0] seed = 32'h0000_0039;
  int err_total = 0;
  int total_checks = 0;

  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  dpram_top dut_u (.clock, .nrst, .hsb_external_data_select_sel, .ia_req, .ia_we, .ia_indirect, .ia_stack, .ia_addr,
    .ia_wdata, .ia_rdata, .ia_done, .ptr_load, .ptr_load_val, .ptr_inc, .data_pointer, .pointer_select,
    .xm_req, .xm_we, .xm_use_ptr, .xm_ri_addr, .xm_wdata, .xm_rdata, .xm_done, .xm_busy,
    .boot_rom_map_enable, .ale_movx_only, .p0_out, .p0_oe, .p0_in, .p2_out, .p2_oe, .rd_n, .wr_n, .ale);
  dpram_ext_mem mem_u (.clock, .ale, .p0_out, .p0_oe, .p2_out, .p2_oe, .rd_n, .wr_n, .slow, .p0_in);

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int lat(input logic bus, str);
    return bus ? 5 + int'(str ? STROBE_LONG_CLKS : STROBE_NORM_CLKS) : 3;
  endfunction

  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic rst(input logic h);
    nrst = 0;
    hsb_external_data_select_sel = h;
    repeat (2) @(posedge clock);
    #1 nrst = 1;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic ia(input logic we, ind, stk, input logic [7:0] ad, wd);
    @(posedge clock) #1;
    {ia_req, ia_we, ia_indirect, ia_stack, ia_addr, ia_wdata} = {1'b1, we, ind, stk, ad, wd};
    @(posedge clock) #1;
    ia_req = 0;
    chk(ia_done, 1);
    q = ia_rdata;
  endtask

  task automatic rd(input logic ind, stk, input logic [7:0] ad, e);
    ia(0, ind, stk, ad, 0);
    chk(q, e);
  endtask

  task automatic pop(input logic ld, inc, input logic [15:0] v);
    @(posedge clock) #1;
    {ptr_load, ptr_inc, ptr_load_val} = {ld, inc, v};
    @(posedge clock) #1;
    {ptr_load, ptr_inc} = 2'h0;
    @(posedge clock) #1;
  endtask

  // Move through pointer or register; watch pins for bus activity and address
  task automatic xm(input logic we, up, input logic [15:0] ad, input logic [7:0] wd, e, input logic bus, str);
    int n = 1;
    logic act = 0, p2 = 0;
    logic [15:0] la = '0;
    @(posedge clock) #1;
    {ptr_load, ptr_load_val} = {up, ad};
    @(posedge clock) #1;
    ptr_load = 0;
    {xm_req, xm_we, xm_use_ptr, xm_ri_addr, xm_wdata} = {1'b1, we, up, ad[7:0], wd};
    @(posedge clock) #1;
    xm_req = 0;
    chk(xm_busy, 1);
    while (!xm_done && n < 60)
    begin
      @(posedge clock) #1;
      n++;
      act |= ale | ~rd_n | ~wr_n | p0_oe;
      p2 |= p2_oe;
      if (ale)
        la = {p2_oe ? p2_out : 8'h00, p0_out};
    end
    chk(xm_busy, 0);
    chk(16'(n), 16'(lat(bus, str)));
    chk(act, bus);
    chk(p2, bus & up);
    if (bus)
      chk(la, up ? ad : {8'h00, ad[7:0]});
    if (!we)
      chk(xm_rdata, e);
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    rst(0);
    chk({rd_n, wr_n, pointer_select}, 3'h6);
    rd(0, 0, SFR_PTR_SEL, 8'h00);
    ia(1, 0, 0, SFR_PTR_SEL, 8'h2D);
    rd(0, 0, SFR_PTR_SEL, 8'h29);
    chk({boot_rom_map_enable, pointer_select}, 2'h3);
    for (int i = 0; i < 2; i++)
    begin
      ia(0, 0, 0, SFR_PTR_SEL, 0);
      ia(1, 0, 0, SFR_PTR_SEL, (q + 8'h01) & 8'h2D);
      rd(0, 0, SFR_PTR_SEL, 8'h28 | 8'(i));
      chk(pointer_select, i);
    end
    v0 = 16'(rnd());
    v1 = 16'(rnd());
    ia(1, 0, 0, SFR_PTR_SEL, 8'h00);
    pop(1, 0, v0);
    ia(1, 0, 0, SFR_PTR_SEL, 8'h01);
    pop(1, 0, v1);
    pop(0, 1, 0);
    v1 = v1 + 16'h0001;
    chk(data_pointer, v1);
    rd(0, 0, SFR_PTR_LO, v1[7:0]);
    rd(0, 0, SFR_PTR_HI, v1[15:8]);
    ia(1, 0, 0, SFR_PTR_SEL, 8'h00);
    ia(1, 0, 0, SFR_PTR_HI, 8'hC3);
    @(posedge clock) #1;
    chk(data_pointer, {8'hC3, v0[7:0]});
    for (int i = 0; i < 6; i++)
    begin
      a = 8'(rnd());
      d = 8'(rnd());
      a = i[0] ? (a | 8'hC0) : (a & 8'h7F);
      ia(1, !i[1], i[1], a, d);
      rd(0, 1, a, d);
      rd(0, 0, a, i[0] ? 8'h00 : d);
    end
    ia(1, 1, 0, SFR_PTR_SEL, 8'h01);
    chk(pointer_select, 0);
    for (int s = 0; s < 4; s++)
    begin
      ia(1, 0, 0, SFR_AUX_MEM, 8'(s << 2));
      xa = 16'(256 * (s + 1));
      d = 8'(rnd());
      xm(1, 1, xa - 16'h0001, d, 0, 0, 0);
      xm(1, 1, xa, ~d, 0, 1, 0);
      xm(0, 1, xa - 16'h0001, 0, d, 0, 0);
      xm(0, 1, xa, 0, ~d, 1, 0);
    end
    ia(1, 0, 0, SFR_AUX_MEM, 8'h2C);
    xm(1, 0, 16'h0044, 8'h5C, 0, 0, 0);
    xm(1, 1, 16'h0144, 8'hA3, 0, 0, 0);
    xm(0, 0, 16'h0044, 0, 8'h5C, 0, 0);
    ia(1, 0, 0, SFR_AUX_MEM, 8'h02);
    xm(1, 0, 16'h0037, 8'h6E, 0, 1, 0);
    xm(0, 1, 16'h0037, 0, 8'h6E, 1, 0);
    ia(1, 0, 0, SFR_AUX_MEM, 8'h22);
    slow = 1;
    xm(0, 1, 16'h0037, 0, 8'h6E, 1, 1);
    xm(1, 1, 16'h2037, 8'h91, 0, 1, 1);
    slow = 0;
    rst(1);
    rd(0, 0, SFR_AUX_MEM, 8'h02);
    xm(0, 0, 16'h0037, 0, 8'h6E, 1, 0);
    ia(1, 0, 0, SFR_AUX_MEM, 8'h03);
    chk(ale_movx_only, 1);
    rd(0, 0, SFR_AUX_MEM, 8'h03);
    report_and_stop();
  end

  // Whole run is near 380 cycles; leave ample room before calling it a hang
  initial
  begin
    #(CLK_PERIOD_NS * 6000);
    err_total++;
    report_and_stop();
  end
endmodule  // dpram_tb_top
